// ---- common/haptic_loop_control_defines.svh ----
// Offsets, field positions, reset values and timing figures of the loop control registers.
// Assumes a register access engine outside that issues one-cycle read and write strobes.
// Notes on behaviour
// - Brake ratio codes 0..6 scale braking gain 1,2,3,4,6,8,16; code 7 disables braking.
// - Loop gain sits at feedback bits 3..2, codes low/medium/high/very high, reset medium.
// - Loop gain setting steers how fast the loop chases the input level.
// - Back-EMF gain at bits 1..0, reset 2, meaning depends on ERM or LRA mode.
// - Calibration completion writes its chosen back-EMF gain into the field.
// - Boost bit 7, reset 1, raises loop gain during the overdrive phase.
// - Coupling bit 5, reset 0, turns on the 0.9 V common-mode drive.
// - LRA: drive time code, reset 0x13, is initial estimate: code*0.1 ms + 0.5 ms.
// - LRA: effective drive time keeps adjusting in real time from that estimate.
// - ERM: drive time code sets sampling interval: code*0.2 ms + 1 ms.
// - Direction bit: 0 unidirectional, 1 (reset) bidirectional where half input is zero.
`ifndef HAPTIC_LOOP_CONTROL_DEFINES_SVH
`define HAPTIC_LOOP_CONTROL_DEFINES_SVH

`define OFS_FEEDBACK_SETUP  8'h1a
`define OFS_LOOP_CTL_ONE    8'h1b
`define OFS_LOOP_CTL_TWO    8'h1c

`define RST_FEEDBACK_SETUP  8'h36
`define RST_LOOP_CTL_ONE    8'h93
`define RST_LOOP_CTL_TWO    8'he5

`define FB_ACT_TYPE_BIT     7
`define FB_BRAKE_MSB        6
`define FB_BRAKE_LSB        4
`define FB_LOOP_GAIN_MSB    3
`define FB_LOOP_GAIN_LSB    2
`define FB_BEMF_MSB         1
`define FB_BEMF_LSB         0
`define C1_BOOST_BIT        7
`define C1_RESERVED_BIT     6
`define C1_AC_COUPLING_ENABLE_BIT    5
`define C1_DRIVE_MSB        4
`define C1_DRIVE_LSB        0
`define C2_DIRECTION_BIT    7
`define C1_WRITE_MASK       8'hbf
`define BRAKE_OFF_CODE      3'h7
`define DRIVE_CODE_MAX      5'h1f

`define CLK_PERIOD_NS       20
`define LRA_STEP_US         100
`define LRA_BASE_US         500
`define ERM_STEP_US         200
`define ERM_BASE_US         1000

`endif

// ---- common/haptic_loop_control_pkg.sv ----
// Types shared by the loop control register block.
// Assumes the defines header is compiled alongside.
package haptic_loop_control_pkg;
  typedef enum logic {
    ACT_ERM = 1'b0,
    ACT_LRA = 1'b1
  } actuator_mode_type;
  typedef logic [1:0] loop_gain_type;
  typedef logic [4:0] drive_code_type;
endpackage

// ---- rtl/haptic_loop_control_regs.sv ----
// Register bank and derived controls of the closed-loop haptic feedback controller.
// Assumes the register strobes and loop signals all come from logic on clk.
`timescale 1ns/1ps
`include "haptic_loop_control_defines.svh"

module haptic_loop_control_regs
  import haptic_loop_control_pkg::*;
#(
  parameter int unsigned LRA_STEP_CYC = (`LRA_STEP_US * 1000) / `CLK_PERIOD_NS,
  parameter int unsigned LRA_BASE_CYC = (`LRA_BASE_US * 1000) / `CLK_PERIOD_NS,
  parameter int unsigned ERM_STEP_CYC = (`ERM_STEP_US * 1000) / `CLK_PERIOD_NS,
  parameter int unsigned ERM_BASE_CYC = (`ERM_BASE_US * 1000) / `CLK_PERIOD_NS
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        regAddr,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [7:0]        regWdata,
  output logic      [7:0]        regRdata,
  input  wire logic              calDone,
  input  wire logic [1:0]        calBemfGain,
  input  wire logic              overdrivePhase,
  input  wire logic              driveAdjUp,
  input  wire logic              driveAdjDown,
  input  wire logic [7:0]        inputLevel,
  output actuator_mode_type      actuatorMode,
  output loop_gain_type          loopGainActive,
  output logic      [1:0]        backemfAmpGain,
  output logic      [4:0]        brakeMultiplier,
  output logic                   brakeEnable,
  output logic                   commonModeDriveEn,
  output drive_code_type         driveCodeActive,
  output logic                   driveIntervalTick,
  output logic signed [8:0]      driveTarget
);

  // Brake ratio code to gain multiplier
  function automatic logic [4:0] brake_mult(input logic [2:0] code);
    unique case (code)
      3'h0: brake_mult = 5'h01;
      3'h1: brake_mult = 5'h02;
      3'h2: brake_mult = 5'h03;
      3'h3: brake_mult = 5'h04;
      3'h4: brake_mult = 5'h06;
      3'h5: brake_mult = 5'h08;
      3'h6: brake_mult = 5'h10;
      3'h7: brake_mult = 5'h00;
    endcase
  endfunction

  // Interval length in cycles for a mode and code, minus one
  function automatic logic [31:0] interval_last(input actuator_mode_type mode,
                                                input drive_code_type code);
    logic [31:0] span;
    span = 32'h0;
    if (mode == ACT_LRA) begin
      span = 32'(LRA_BASE_CYC) + 32'(code) * 32'(LRA_STEP_CYC);
    end else begin
      span = 32'(ERM_BASE_CYC) + 32'(code) * 32'(ERM_STEP_CYC);
    end
    interval_last = span - 32'h1;
  endfunction

  logic [7:0]        fbSetup_reg,   fbSetup_next;
  logic [7:0]        ctlOne_reg,    ctlOne_next;
  logic [7:0]        ctlTwo_reg,    ctlTwo_next;
  logic [7:0]        rdata_reg,     rdata_next;
  drive_code_type    driveCode_reg, driveCode_next;
  logic [31:0]       tickCnt_reg,   tickCnt_next;
  logic              tick_reg,      tick_next;
  loop_gain_type     gainAct_reg,   gainAct_next;
  logic [4:0]        brakeMul_reg,  brakeMul_next;
  logic              brakeEn_reg,   brakeEn_next;
  logic signed [8:0] target_reg,    target_next;

  logic              wrFb;
  logic              wrOne;
  logic              wrTwo;
  actuator_mode_type modeNow;
  loop_gain_type     gainField;

  assign wrFb      = regWrite && (regAddr == `OFS_FEEDBACK_SETUP);
  assign wrOne     = regWrite && (regAddr == `OFS_LOOP_CTL_ONE);
  assign wrTwo     = regWrite && (regAddr == `OFS_LOOP_CTL_TWO);
  assign modeNow   = actuator_mode_type'(fbSetup_reg[`FB_ACT_TYPE_BIT]);
  assign gainField = fbSetup_reg[`FB_LOOP_GAIN_MSB:`FB_LOOP_GAIN_LSB];

  // Register writes; calibration result beats a host write in the same cycle
  always_comb begin
    fbSetup_next = fbSetup_reg;
    ctlOne_next  = ctlOne_reg;
    ctlTwo_next  = ctlTwo_reg;
    if (wrFb) begin
      fbSetup_next = regWdata;
    end
    if (calDone) begin
      fbSetup_next[`FB_BEMF_MSB:`FB_BEMF_LSB] = calBemfGain;
    end
    if (wrOne) begin
      ctlOne_next = regWdata & `C1_WRITE_MASK;
    end
    if (wrTwo) begin
      ctlTwo_next = regWdata;
    end
  end

  // Read data is registered, so it is valid the cycle after the strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (regRead) begin
      unique case (regAddr)
        `OFS_FEEDBACK_SETUP: rdata_next = fbSetup_reg;
        `OFS_LOOP_CTL_ONE:   rdata_next = ctlOne_reg & `C1_WRITE_MASK;
        `OFS_LOOP_CTL_TWO:   rdata_next = ctlTwo_reg;
        default:             rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fbSetup_reg <= `RST_FEEDBACK_SETUP;
      ctlOne_reg  <= `RST_LOOP_CTL_ONE;
      ctlTwo_reg  <= `RST_LOOP_CTL_TWO;
      rdata_reg   <= 8'h00;
    end else begin
      fbSetup_reg <= fbSetup_next;
      ctlOne_reg  <= ctlOne_next;
      ctlTwo_reg  <= ctlTwo_next;
      rdata_reg   <= rdata_next;
    end
  end

  // Effective drive code: LRA tracks loop trims, ERM follows the field as written
  always_comb begin
    driveCode_next = driveCode_reg;
    if (wrOne) begin
      driveCode_next = regWdata[`C1_DRIVE_MSB:`C1_DRIVE_LSB];
    end else if (modeNow == ACT_ERM) begin
      driveCode_next = ctlOne_reg[`C1_DRIVE_MSB:`C1_DRIVE_LSB];
    end else if (driveAdjUp && !driveAdjDown && driveCode_reg != `DRIVE_CODE_MAX) begin
      driveCode_next = driveCode_reg + 5'h01;
    end else if (driveAdjDown && !driveAdjUp && driveCode_reg != 5'h00) begin
      driveCode_next = driveCode_reg - 5'h01;
    end
  end

  // Interval timer; a shortened code takes effect at once rather than next period
  always_comb begin
    tickCnt_next = tickCnt_reg + 32'h1;
    tick_next    = 1'b0;
    if (tickCnt_reg >= interval_last(modeNow, driveCode_reg)) begin
      tickCnt_next = 32'h0;
      tick_next    = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      driveCode_reg <= 5'h13;
      tickCnt_reg   <= 32'h0;
      tick_reg      <= 1'b0;
    end else begin
      driveCode_reg <= driveCode_next;
      tickCnt_reg   <= tickCnt_next;
      tick_reg      <= tick_next;
    end
  end

  // Gain and input shaping for the loop
  always_comb begin
    gainAct_next = gainField;
    if (ctlOne_reg[`C1_BOOST_BIT] && overdrivePhase && gainField != 2'h3) begin
      gainAct_next = gainField + 2'h1;
    end
    brakeMul_next = brake_mult(fbSetup_reg[`FB_BRAKE_MSB:`FB_BRAKE_LSB]);
    brakeEn_next  = fbSetup_reg[`FB_BRAKE_MSB:`FB_BRAKE_LSB] != `BRAKE_OFF_CODE;
    if (ctlTwo_reg[`C2_DIRECTION_BIT]) begin
      target_next = $signed({1'b0, inputLevel}) - 9'sh080;
    end else begin
      target_next = $signed({1'b0, inputLevel});
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gainAct_reg  <= 2'h1;
      brakeMul_reg <= 5'h04;
      brakeEn_reg  <= 1'b1;
      target_reg   <= 9'sh000;
    end else begin
      gainAct_reg  <= gainAct_next;
      brakeMul_reg <= brakeMul_next;
      brakeEn_reg  <= brakeEn_next;
      target_reg   <= target_next;
    end
  end

  assign regRdata          = rdata_reg;
  assign actuatorMode      = modeNow;
  assign loopGainActive    = gainAct_reg;
  assign backemfAmpGain    = fbSetup_reg[`FB_BEMF_MSB:`FB_BEMF_LSB];
  assign brakeMultiplier   = brakeMul_reg;
  assign brakeEnable       = brakeEn_reg;
  assign commonModeDriveEn = ctlOne_reg[`C1_AC_COUPLING_ENABLE_BIT];
  assign driveCodeActive   = driveCode_reg;
  assign driveIntervalTick = tick_reg;
  assign driveTarget       = target_reg;

  sequence s_quiet;
    !driveIntervalTick [*8];
  endsequence

  property p_brake_off;
    @(posedge clk) disable iff (sys_rst)
      wrFb && regWdata[6:4] == 3'h7 && !calDone |=> ##1 !brakeEnable && brakeMultiplier == 5'h00;
  endproperty
  a_brake_off: assert property (p_brake_off) else $error("brake not disabled");

  property p_brake_16;
    @(posedge clk) disable iff (sys_rst)
      wrFb && regWdata[6:4] == 3'h6 |=> ##1 brakeEnable && brakeMultiplier == 5'h10;
  endproperty
  a_brake_16: assert property (p_brake_16) else $error("brake ratio 16 wrong");

  property p_gain_reset;
    @(posedge clk) sys_rst ##1 !sys_rst |-> gainField == 2'h1 && backemfAmpGain == 2'h2;
  endproperty
  a_gain_reset: assert property (p_gain_reset) else $error("gain reset wrong");

  property p_cal_gain;
    @(posedge clk) disable iff (sys_rst)
      calDone |=> backemfAmpGain == $past(calBemfGain);
  endproperty
  a_cal_gain: assert property (p_cal_gain) else $error("calibration gain lost");

  property p_boost;
    @(posedge clk) disable iff (sys_rst)
      ctlOne_reg[7] && overdrivePhase && gainField == 2'h1 |=> loopGainActive == 2'h2;
  endproperty
  a_boost: assert property (p_boost) else $error("boost not applied");

  property p_common_mode;
    @(posedge clk) disable iff (sys_rst)
      wrOne |=> commonModeDriveEn == $past(regWdata[5]);
  endproperty
  a_common_mode: assert property (p_common_mode) else $error("common mode wrong");

  property p_lra_seed;
    @(posedge clk) disable iff (sys_rst)
      wrOne |=> driveCodeActive == $past(regWdata[4:0]);
  endproperty
  a_lra_seed: assert property (p_lra_seed) else $error("drive code not loaded");

  property p_lra_trim;
    @(posedge clk) disable iff (sys_rst)
      actuatorMode == ACT_LRA && !wrOne && driveAdjUp && !driveAdjDown
        && driveCodeActive != 5'h1f |=> driveCodeActive == $past(driveCodeActive) + 5'h01;
  endproperty
  a_lra_trim: assert property (p_lra_trim) else $error("drive trim missed");

  // Down trim saturates at zero, so only a code above zero must move
  property p_lra_trim_down;
    @(posedge clk) disable iff (sys_rst)
      actuatorMode == ACT_LRA && !wrOne && driveAdjDown && !driveAdjUp
        && driveCodeActive != 5'h00 |=> driveCodeActive == $past(driveCodeActive) - 5'h01;
  endproperty
  a_lra_trim_down: assert property (p_lra_trim_down) else $error("trim down missed");

  // Opposing pulses in one cycle cancel rather than race
  property p_lra_trim_hold;
    @(posedge clk) disable iff (sys_rst)
      actuatorMode == ACT_LRA && !wrOne && driveAdjUp && driveAdjDown
        |=> $stable(driveCodeActive);
  endproperty
  a_lra_trim_hold: assert property (p_lra_trim_hold) else $error("trim not held");

  // ERM ignores loop trims and always follows the programmed field
  property p_erm_follow;
    @(posedge clk) disable iff (sys_rst)
      actuatorMode == ACT_ERM && !wrOne
        |=> driveCodeActive == $past(ctlOne_reg[`C1_DRIVE_MSB:`C1_DRIVE_LSB]);
  endproperty
  a_erm_follow: assert property (p_erm_follow) else $error("ERM drive code stale");

  property p_tick_spacing;
    @(posedge clk) disable iff (sys_rst)
      driveIntervalTick |=> s_quiet;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("interval too short");

  property p_bidir_mid;
    @(posedge clk) disable iff (sys_rst)
      ctlTwo_reg[7] && inputLevel == 8'h80 |=> driveTarget == 9'sh000;
  endproperty
  a_bidir_mid: assert property (p_bidir_mid) else $error("midscale not zero");

  property p_unidir;
    @(posedge clk) disable iff (sys_rst)
      !ctlTwo_reg[`C2_DIRECTION_BIT] |=> driveTarget == $signed({1'b0, $past(inputLevel)});
  endproperty
  a_unidir: assert property (p_unidir) else $error("unidirectional target wrong");

  property p_reserved;
    @(posedge clk) disable iff (sys_rst)
      regRead && regAddr == 8'h1b |=> regRdata[6] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

endmodule // haptic_loop_control_regs

// ---- test/haptic_loop_control_regs_bench.sv ----
// Self-checking bench for the loop control registers, against an integer model.
// Assumes small interval parameters so tick periods stay short.
`timescale 1ns/1ps
module haptic_loop_control_regs_bench;
  import haptic_loop_control_pkg::*;
  localparam int LS = 2, LB = 10, ES = 3, EB = 12;
  logic              clk, sysRst, regWrite, regRead, calDone, overdrivePhase;
  logic              driveAdjUp, driveAdjDown, brakeEnable, commonModeDriveEn;
  logic              driveIntervalTick;
  logic [7:0]        regAddr, regWdata, regRdata, inputLevel, rd;
  logic [1:0]        calBemfGain, backemfAmpGain;
  logic [4:0]        brakeMultiplier;
  actuator_mode_type actuatorMode;
  loop_gain_type     loopGainActive;
  drive_code_type    driveCodeActive;
  logic signed [8:0] driveTarget;
  int                failures, num_checks, seed, cycles, n, fbReg, c1Reg, c2Reg;
  int                brakeTab[8] = '{1, 2, 3, 4, 6, 8, 16, 0};

  host_model host (.clk(clk), .regRdata(regRdata), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata));
  haptic_loop_control_regs #(.LRA_STEP_CYC(LS), .LRA_BASE_CYC(LB), .ERM_STEP_CYC(ES),
    .ERM_BASE_CYC(EB)) i_dut (.clk(clk), .sys_rst(sysRst), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .calDone(calDone), .calBemfGain(calBemfGain), .overdrivePhase(overdrivePhase),
    .driveAdjUp(driveAdjUp), .driveAdjDown(driveAdjDown), .inputLevel(inputLevel),
    .actuatorMode(actuatorMode), .loopGainActive(loopGainActive),
    .backemfAmpGain(backemfAmpGain), .brakeMultiplier(brakeMultiplier),
    .brakeEnable(brakeEnable), .commonModeDriveEn(commonModeDriveEn),
    .driveCodeActive(driveCodeActive), .driveIntervalTick(driveIntervalTick),
    .driveTarget(driveTarget));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard: far above the roughly 1000 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input int exp, input logic [8:0] got);
    num_checks++;
    if (got !== exp[8:0]) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp[8:0], got);
    end
  endtask
  task automatic readCheck(input logic [7:0] a, input int exp);
    host.hostRead(a, rd);
    check("regRdata", exp, {1'b0, rd});
  endtask
  // Write and update the model; registered gain, brake and target outputs lag one more cycle
  task automatic wr(input logic [7:0] a, input int d);
    host.hostWrite(a, d[7:0], 0);
    if (a == 8'h1a) fbReg = d & 'hff;
    if (a == 8'h1b) c1Reg = d & 'hbf;
    if (a == 8'h1c) c2Reg = d & 'hff;
    repeat (2) @(posedge clk);
  endtask
  task automatic derived();
    int g;
    g = (fbReg >> 2) & 3;
    if (((c1Reg >> 7) & 1) && overdrivePhase && g < 3) g++;
    check("loopGainActive", g, loopGainActive);
    check("brakeMultiplier", brakeTab[(fbReg >> 4) & 7], brakeMultiplier);
    check("brakeEnable", ((fbReg >> 4) & 7) != 7, brakeEnable);
    check("backemfAmpGain", fbReg & 3, backemfAmpGain);
    check("commonModeDriveEn", (c1Reg >> 5) & 1, commonModeDriveEn);
    check("actuatorMode", (fbReg >> 7) & 1, actuatorMode);
    check("driveTarget", c2Reg[7] ? inputLevel - 128 : inputLevel, driveTarget);
  endtask
  task automatic waitTick(output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (driveIntervalTick !== 1'b1 && k < 300);
  endtask
  // Third interval after a change is a clean full period
  task automatic tickPeriod(input int exp);
    repeat (3) waitTick(n);
    check("tickPeriod", exp, n[8:0]);
  endtask
  task automatic trim(input logic up, input logic dn, input int exp);
    driveAdjUp <= up;
    driveAdjDown <= dn;
    @(posedge clk);
    driveAdjUp <= 1'b0;
    driveAdjDown <= 1'b0;
    repeat (2) @(posedge clk);
    check("driveCodeActive", exp, driveCodeActive);
  endtask

  initial begin
    seed = 26738;
    {sysRst, calDone, overdrivePhase, driveAdjUp, driveAdjDown} = 5'h10;
    inputLevel = 8'h80;
    calBemfGain = 2'h0;
    repeat (2) begin
      fbReg = 'h36;
      c1Reg = 'h93;
      c2Reg = 'he5;
      repeat (4) @(posedge clk);
      sysRst <= 1'b0;
      readCheck(8'h1a, 'h36);
      readCheck(8'h1b, 'h93);
      readCheck(8'h1c, 'he5);
      readCheck(8'h55, 0);
      derived();
      check("driveCodeActive", 'h13, driveCodeActive);
      $display("test reset done");
      // Every brake code and loop gain, boost in and out of overdrive
      for (int i = 0; i < 8; i++) begin
        overdrivePhase <= i[0];
        inputLevel <= $random(seed);
        wr(8'h1a, (i << 4) | ((i & 3) << 2) | (i & 3));
        derived();
      end
      wr(8'h1b, 'h13);
      derived();
      wr(8'h1c, 'h65);
      readCheck(8'h1c, 'h65);
      derived();
      $display("test gains done");
      // Calibration result lands in the back-EMF gain field
      calBemfGain <= $random(seed);
      calDone <= 1'b1;
      @(posedge clk);
      calDone <= 1'b0;
      fbReg = (fbReg & 'hfc) | calBemfGain;
      repeat (2) @(posedge clk);
      derived();
      $display("test calibration done");
      // Reserved bit, coupling, ERM interval ends, trim ignored in ERM
      wr(8'h1b, 'hff);
      readCheck(8'h1b, 'hbf);
      derived();
      tickPeriod(EB + 31 * ES);
      trim(1'b1, 1'b0, 31);
      wr(8'h1b, 'h80);
      trim(1'b1, 1'b0, 0);
      tickPeriod(EB);
      // LRA estimate then real-time trim
      wr(8'h1a, 'hb6);
      wr(8'h1b, 'h85);
      tickPeriod(LB + 5 * LS);
      trim(1'b1, 1'b0, 6);
      tickPeriod(LB + 6 * LS);
      trim(1'b1, 1'b1, 6);
      trim(1'b0, 1'b1, 5);
      $display("test drive time done");
      sysRst <= 1'b1;
    end
    tally_and_finish();
  end
endmodule // haptic_loop_control_regs_bench

// ---- test/host_model.sv ----
// Host side of the register strobes: one-cycle writes and reads.
// Assumes the bench calls these tasks from a single process on clk.
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdata,
  output logic      [7:0] regAddr,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regWdata
);
  // Idle bus at time zero
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 8'h00;
  end
  // Loop gain set before any calibration pulse coupling set only as an
  // analog-input host would LRA codes are picked as half-period guesses
  task automatic hostWrite(input logic [7:0] a, input logic [7:0] d, input int gap);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regWdata <= ~d; // Stale data must not pass for a write
    repeat (gap) @(posedge clk);
  endtask
  // Read data is registered, so it is taken one edge after the strobe
  task automatic hostRead(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask
endmodule // host_model
